// [design/pcr_evt_xfer.sv]
// Toggle based crossing of single-cycle events between two clocks.
`timescale 1ns/1ns
module pcr_evt_xfer (
	// Source side
	input wire logic src_clk,
	input wire logic src_rst,
	input wire logic src_pulse,
	// Destination side
	input wire logic dst_clk,
	input wire logic dst_rst,
	output logic dst_pulse
);

	logic tog_r;
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge src_clk) begin
		if (src_rst) begin
			tog_r <= 1'b0;
		end else if (src_pulse) begin
			tog_r <= ~tog_r;
		end
	end

	// Events closer than two destination cycles may merge.
	always_ff @(posedge dst_clk) begin
		if (dst_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= tog_r;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign dst_pulse = s2_r ^ s3_r;

endmodule

// [design/pcr_map.svh]
// Offsets, field positions, reset values and counts of the control registers.
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// ----------------------------------------------------------------
// Host I/O offsets (byte addresses within the I/O range)
// ----------------------------------------------------------------
`define PCR_OFS_HOST_STATUS 4'h0
`define PCR_OFS_HOST_CTRL 4'h4
`define PCR_OFS_PAGE_SEL 4'h8

// ----------------------------------------------------------------
// Host status fields
// ----------------------------------------------------------------
`define PCR_HS_FLAG_BIT 0
`define PCR_HS_LINE_BIT 1
`define PCR_HS_MASK_BIT 2

// ----------------------------------------------------------------
// Host-to-core control fields
// ----------------------------------------------------------------
`define PCR_HC_SOFT_RST_BIT 0
`define PCR_HC_IRQ_BIT 1
`define PCR_HC_BOOT_BIT 2

// ----------------------------------------------------------------
// Page select fields
// ----------------------------------------------------------------
`define PCR_PG_PAGE_W 10
`define PCR_PG_MAP_BIT 10
`define PCR_PG_PAGE_RST 10'h000

// ----------------------------------------------------------------
// Reset source/status fields
// ----------------------------------------------------------------
`define PCR_RS_DEV_BIT 0
`define PCR_RS_BUS_BIT 1
`define PCR_RS_SOFT_BIT 2
`define PCR_RS_REQ_BIT 3
`define PCR_RS_REARM_BIT 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCR_SOFT_HOLD_CYC 16

`endif

// [design/pcr_pkg.sv]
// Types shared by the control register block.
package pcr_pkg;

	typedef struct packed {
		logic sel;
		logic wr;
		logic [3:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcr_host_req_t;

	typedef struct packed {
		logic sel;
		logic wr;
		logic [31:0] wdata;
	} pcr_core_req_t;

endpackage

// [design/pcr_regs.sv]
// Host status, control and page registers of the bus port and the reset source/status register of the core port.
`timescale 1ns/1ns
`include "pcr_map.svh"
module pcr_regs import pcr_pkg::*; #(
	parameter int HOLD_CYC = `PCR_SOFT_HOLD_CYC
) (
	// Core clock and device reset
	input wire logic mclk,
	input wire logic rst,
	// Bus clock
	input wire logic pci_clk,
	// Pins
	input wire logic pci_rst_n,
	input wire logic boot_strap,
	input wire logic map_strap,
	// Host I/O port, bus clock
	input wire pcr_host_req_t host_req,
	output logic [31:0] host_rdata_r,
	output logic host_rvalid_r,
	// Memory-mapped port, core clock
	input wire pcr_core_req_t core_req,
	output logic [31:0] core_rdata_r,
	output logic core_rvalid_r,
	// Core status, core clock
	input wire logic core_clk_on,
	input wire logic host_software_source_en,
	input wire logic pm_warm_req,
	// Core controls
	output logic host_software_source_r,
	output logic core_boot_hold_r,
	output logic core_soft_hold_r,
	output logic [`PCR_PG_PAGE_W-1:0] page_r,
	// Interrupt pin, open drain
	output logic bus_irq_line_o_r,
	output logic bus_irq_line_oe_r
);

	localparam int CW = $clog2(HOLD_CYC + 1);
	localparam logic [CW-1:0] HOLD_LD = CW'(HOLD_CYC);

	// ----------------------------------------------------------------
	// Crossings
	// ----------------------------------------------------------------
	logic bus_reset_seen_m;
	logic bus_reset_seen_p;
	logic dev_rst_p;
	logic p_rst;
	logic [1:0] strap_m;
	logic boot_r;
	logic map_r;
	logic [1:0] boot_map_p;
	logic mask_r;
	logic mask_m;
	logic irq_evt_p;
	logic irq_evt_m;
	logic soft_evt_p;
	logic soft_evt_m;
	logic assert_evt_m;
	logic assert_evt_p;
	logic rearm_evt_m;
	logic rearm_evt_p;

	pcr_sync #(.W(1)) u_bus_reset_seen_m (
		.clk(mclk), .rst(1'b0), .d(~pci_rst_n), .q(bus_reset_seen_m)
	);
	pcr_sync #(.W(1)) u_bus_reset_seen_p (
		.clk(pci_clk), .rst(1'b0), .d(~pci_rst_n), .q(bus_reset_seen_p)
	);
	pcr_sync #(.W(1)) u_rst_p (
		.clk(pci_clk), .rst(1'b0), .d(rst), .q(dev_rst_p)
	);
	// Straps are not reset so they are valid at the release.
	pcr_sync #(.W(2)) u_strap (
		.clk(mclk), .rst(1'b0), .d({map_strap, boot_strap}), .q(strap_m)
	);
	pcr_sync #(.W(2)) u_bm_p (
		.clk(pci_clk), .rst(dev_rst_p), .d({map_r, boot_r}),
		.q(boot_map_p)
	);
	pcr_sync #(.W(1)) u_mask_m (
		.clk(mclk), .rst(rst), .d(mask_r), .q(mask_m)
	);
	// Event crossings clear on device reset only; a bus reset on one side
	// alone would flip a toggle and read as a false event on the other.
	pcr_evt_xfer u_irq_x (
		.src_clk(pci_clk), .src_rst(dev_rst_p), .src_pulse(irq_evt_p),
		.dst_clk(mclk), .dst_rst(rst), .dst_pulse(irq_evt_m)
	);
	pcr_evt_xfer u_soft_x (
		.src_clk(pci_clk), .src_rst(dev_rst_p), .src_pulse(soft_evt_p),
		.dst_clk(mclk), .dst_rst(rst), .dst_pulse(soft_evt_m)
	);
	pcr_evt_xfer u_asrt_x (
		.src_clk(mclk), .src_rst(rst), .src_pulse(assert_evt_m),
		.dst_clk(pci_clk), .dst_rst(dev_rst_p), .dst_pulse(assert_evt_p)
	);
	pcr_evt_xfer u_rearm_x (
		.src_clk(mclk), .src_rst(rst), .src_pulse(rearm_evt_m),
		.dst_clk(pci_clk), .dst_rst(dev_rst_p), .dst_pulse(rearm_evt_p)
	);

	// ----------------------------------------------------------------
	// Core domain: straps and boot hold
	// ----------------------------------------------------------------
	logic rst_d_r;
	logic strap_take;

	assign strap_take = rst_d_r & ~rst;

	always_ff @(posedge mclk) begin
		rst_d_r <= rst;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			boot_r <= 1'b0;
			map_r <= 1'b0;
		end else if (strap_take) begin
			boot_r <= strap_m[0];
			map_r <= strap_m[1];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			core_boot_hold_r <= 1'b1;
		end else if (strap_take) begin
			core_boot_hold_r <= strap_m[0];
		end else if (irq_evt_m & boot_r) begin
			core_boot_hold_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Core domain: host interrupt to the core
	// ----------------------------------------------------------------
	logic hsw_nxt;

	assign hsw_nxt = irq_evt_m & ~boot_r & core_clk_on & host_software_source_en;

	always_ff @(posedge mclk) begin
		if (rst) begin
			host_software_source_r <= 1'b0;
		end else begin
			host_software_source_r <= hsw_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Core domain: bus interrupt request and rearm
	// ----------------------------------------------------------------
	logic core_wr;
	logic core_rd;
	logic rearm_w;
	logic req_eff;
	logic armed_r;
	logic armed_nxt;

	assign core_wr = core_req.sel & core_req.wr;
	assign core_rd = core_req.sel & ~core_req.wr;
	assign rearm_w = core_wr & core_req.wdata[`PCR_RS_REARM_BIT];
	// A request taken while masked is dropped, not held for later.
	assign req_eff = core_wr & core_req.wdata[`PCR_RS_REQ_BIT] & ~mask_m
		& (armed_r | rearm_w);
	assign armed_nxt = req_eff ? 1'b0 : (rearm_w ? 1'b1 : armed_r);

	always_ff @(posedge mclk) begin
		if (rst | soft_evt_m) begin
			armed_r <= 1'b1;
			assert_evt_m <= 1'b0;
			rearm_evt_m <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
			assert_evt_m <= req_eff;
			rearm_evt_m <= rearm_w;
		end
	end

	// ----------------------------------------------------------------
	// Core domain: reset source/status
	// ----------------------------------------------------------------
	logic dev_seen_r;
	logic bus_reset_seen_r;
	logic soft_reset_seen_r;
	logic [31:0] rs_rdata;

	always_ff @(posedge mclk) begin
		if (rst) begin
			dev_seen_r <= 1'b1;
			bus_reset_seen_r <= 1'b0;
			soft_reset_seen_r <= 1'b0;
		end else begin
			if (core_rd) begin
				dev_seen_r <= 1'b0;
			end
			if (bus_reset_seen_m) begin
				bus_reset_seen_r <= 1'b1;
			end else if (core_rd) begin
				bus_reset_seen_r <= 1'b0;
			end
			if (soft_evt_m | pm_warm_req) begin
				soft_reset_seen_r <= 1'b1;
			end else if (core_rd) begin
				soft_reset_seen_r <= 1'b0;
			end
		end
	end

	assign rs_rdata = {29'h0000_0000, soft_reset_seen_r,
		bus_reset_seen_r | bus_reset_seen_m, dev_seen_r};

	always_ff @(posedge mclk) begin
		if (rst) begin
			core_rdata_r <= 32'h0000_0000;
			core_rvalid_r <= 1'b0;
		end else begin
			core_rdata_r <= core_rd ? rs_rdata : 32'h0000_0000;
			core_rvalid_r <= core_rd;
		end
	end

	// ----------------------------------------------------------------
	// Bus domain: host decode
	// ----------------------------------------------------------------
	logic host_wr;
	logic host_rd;
	logic sel_hs;
	logic sel_hc;
	logic sel_pg;
	logic b0_wr;
	logic flag_w1c;

	assign p_rst = bus_reset_seen_p | dev_rst_p;
	assign host_wr = host_req.sel & host_req.wr;
	assign host_rd = host_req.sel & ~host_req.wr;
	assign sel_hs = host_req.addr == `PCR_OFS_HOST_STATUS;
	assign sel_hc = host_req.addr == `PCR_OFS_HOST_CTRL;
	assign sel_pg = host_req.addr == `PCR_OFS_PAGE_SEL;
	assign b0_wr = host_wr & host_req.be[0];
	assign flag_w1c = b0_wr & sel_hs & host_req.wdata[`PCR_HS_FLAG_BIT];
	assign irq_evt_p = b0_wr & sel_hc & host_req.wdata[`PCR_HC_IRQ_BIT];
	// The host keeps this write to D0; no power state is checked here.
	assign soft_evt_p = b0_wr & sel_hc
		& host_req.wdata[`PCR_HC_SOFT_RST_BIT];

	// ----------------------------------------------------------------
	// Bus domain: soft reset hold
	// ----------------------------------------------------------------
	logic [CW-1:0] hold_cnt_r;
	logic [CW-1:0] hold_cnt_nxt;

	assign hold_cnt_nxt = soft_evt_p ? HOLD_LD :
		(hold_cnt_r != '0 ? hold_cnt_r - 1'b1 : hold_cnt_r);

	always_ff @(posedge pci_clk) begin
		if (dev_rst_p) begin
			hold_cnt_r <= '0;
			core_soft_hold_r <= 1'b0;
		end else begin
			hold_cnt_r <= hold_cnt_nxt;
			core_soft_hold_r <= hold_cnt_nxt != '0;
		end
	end

	// ----------------------------------------------------------------
	// Bus domain: page, mask, flag and interrupt line
	// ----------------------------------------------------------------
	logic bus_irq_flag_r;
	logic line_r;
	logic line_nxt;
	logic mask_nxt;

	assign mask_nxt = (b0_wr & sel_hs) ?
		host_req.wdata[`PCR_HS_MASK_BIT] : mask_r;
	assign line_nxt = assert_evt_p ? 1'b1 :
		((rearm_evt_p | flag_w1c) ? 1'b0 : line_r);

	always_ff @(posedge pci_clk) begin
		if (p_rst) begin
			page_r <= `PCR_PG_PAGE_RST;
			mask_r <= 1'b0;
			bus_irq_flag_r <= 1'b0;
			line_r <= 1'b0;
			bus_irq_line_oe_r <= 1'b0;
		end else begin
			if (b0_wr & sel_pg) begin
				page_r[7:0] <= host_req.wdata[7:0];
			end
			if (host_wr & host_req.be[1] & sel_pg) begin
				page_r[9:8] <= host_req.wdata[9:8];
			end
			mask_r <= mask_nxt;
			if (assert_evt_p) begin
				bus_irq_flag_r <= 1'b1;
			end else if (flag_w1c) begin
				bus_irq_flag_r <= 1'b0;
			end
			line_r <= line_nxt;
			bus_irq_line_oe_r <= line_nxt & ~mask_nxt;
		end
	end

	// The pin is only ever pulled low; the enable carries the level.
	always_ff @(posedge pci_clk) begin
		bus_irq_line_o_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Bus domain: host read data
	// ----------------------------------------------------------------
	logic [31:0] hs_rdata;
	logic [31:0] hc_rdata;
	logic [31:0] pg_rdata;
	logic [31:0] host_rdata_nxt;

	assign hs_rdata = {29'h0000_0000, mask_r, bus_irq_line_oe_r,
		bus_irq_flag_r};
	// Command bits read back as zero.
	assign hc_rdata = {29'h0000_0000, boot_map_p[0], 2'b00};
	assign pg_rdata = {21'h00_0000, boot_map_p[1], page_r};
	assign host_rdata_nxt = sel_hs ? hs_rdata :
		(sel_hc ? hc_rdata : (sel_pg ? pg_rdata : 32'h0000_0000));

	always_ff @(posedge pci_clk) begin
		if (p_rst) begin
			host_rdata_r <= 32'h0000_0000;
			host_rvalid_r <= 1'b0;
		end else begin
			host_rdata_r <= host_rd ? host_rdata_nxt : 32'h0000_0000;
			host_rvalid_r <= host_rd;
		end
	end

endmodule

// [design/pcr_sync.sv]
// Two flip-flop level synchroniser.
`timescale 1ns/1ns
module pcr_sync #(
	parameter int W = 1
) (
	// Destination clock
	input wire logic clk,
	input wire logic rst,
	// Level
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= '0;
			q <= '0;
		end else begin
			s1_r <= d;
			q <= s1_r;
		end
	end

endmodule

// [test/pcr_host_model.sv]
// Bus host model that issues single word I/O accesses.
`timescale 1ns/1ns
module pcr_host_model import pcr_pkg::*; (
	// Bus clock
	input wire logic pci_clk,
	// Host I/O port
	output pcr_host_req_t host_req,
	input wire logic [31:0] host_rdata_r,
	input wire logic host_rvalid_r
);
	initial host_req = '0;
	// Soft reset is only issued with the device in D0.
	task acc(input logic w, input logic [3:0] a, input logic [3:0] be,
		input logic [31:0] v, output logic [31:0] q);
		@(negedge pci_clk);
		host_req <= '{1'b1, w, a, be, v};
		@(negedge pci_clk);
		q = host_rvalid_r ? host_rdata_r : 32'hdead_beef;
		// Released lines flip so a stale value cannot pass for a live one.
		host_req <= '{1'b0, 1'b0, ~a, ~be, ~v};
	endtask
endmodule

// [test/pcr_regs_asserts.sv]
// Concurrent checks on the ports of the control register block.
`timescale 1ns/1ns
module pcr_regs_asserts import pcr_pkg::*; #(
	parameter int HOLD_CYC = 16
) (
	// Clocks and resets
	input wire logic mclk,
	input wire logic rst,
	input wire logic pci_clk,
	input wire logic pci_rst_n,
	// Requests
	input wire pcr_host_req_t host_req,
	input wire pcr_core_req_t core_req,
	input wire logic core_clk_on,
	input wire logic host_software_source_en,
	// Answers
	input wire logic [31:0] host_rdata_r,
	input wire logic host_rvalid_r,
	input wire logic [31:0] core_rdata_r,
	input wire logic core_rvalid_r,
	input wire logic host_software_source_r,
	input wire logic core_boot_hold_r,
	input wire logic core_soft_hold_r,
	input wire logic [9:0] page_r,
	input wire logic bus_irq_line_o_r,
	input wire logic bus_irq_line_oe_r
);
	// --------
	// Hold length counter and sequences
	// --------
	logic [7:0] hold_cnt_r;
	logic [7:0] hold_cnt_nxt;
	assign hold_cnt_nxt = core_soft_hold_r ? hold_cnt_r + 8'h01 : 8'h00;
	always_ff @(posedge pci_clk) hold_cnt_r <= rst ? 8'h00 : hold_cnt_nxt;
	sequence s_crd;
		core_req.sel && !core_req.wr;
	endsequence
	sequence s_hacc(logic w, logic [3:0] a);
		host_req.sel && host_req.wr == w && host_req.addr == a;
	endsequence
	property p_page;
		@(posedge pci_clk) disable iff (rst || !pci_rst_n)
		s_hacc(1'b1, 4'h8) ##0 host_req.be == 4'hf
		|=> page_r == $past(host_req.wdata[9:0]);
	endproperty
	AST_HC_RD: assert property (@(posedge pci_clk)
		disable iff (rst || !pci_rst_n) s_hacc(1'b0, 4'h4) |=> host_rvalid_r
		&& host_rdata_r[31:3] == '0 && host_rdata_r[1:0] == 2'b00)
		else $error("control read shows reserved or write-only bits");
	AST_PG_WR: assert property (p_page)
		else $error("page field did not take the written value");
	AST_SOFT_GO: assert property (@(posedge pci_clk)
		disable iff (rst || !pci_rst_n) s_hacc(1'b1, 4'h4)
		##0 (host_req.be[0] && host_req.wdata[0]) |=> core_soft_hold_r)
		else $error("soft reset write did not hold the core");
	AST_SOFT_LEN: assert property (@(posedge pci_clk)
		disable iff (rst) $fell(core_soft_hold_r) |-> hold_cnt_r == HOLD_CYC)
		else $error("soft reset hold has the wrong length");
	AST_OD: assert property (@(posedge pci_clk)
		disable iff (rst) bus_irq_line_o_r == 1'b0)
		else $error("interrupt pin driven high");
	AST_MASK: assert property (@(posedge pci_clk)
		disable iff (rst || !pci_rst_n) s_hacc(1'b1, 4'h0)
		##0 (host_req.be[0] && host_req.wdata[2]) |=> !bus_irq_line_oe_r)
		else $error("interrupt pin driven while masked");
	AST_CRD: assert property (@(posedge mclk)
		disable iff (rst) s_crd |=> core_rvalid_r && core_rdata_r[31:3] == '0)
		else $error("core read shows write-only or reserved bits");
	AST_DEV_CLR: assert property (@(posedge mclk)
		disable iff (rst) s_crd ##[1:4] s_crd |=> !core_rdata_r[0])
		else $error("device reset flag not cleared by read");
	AST_BUS_HELD: assert property (@(posedge mclk)
		disable iff (rst) !pci_rst_n [*4] ##0 s_crd |=> core_rdata_r[1])
		else $error("bus reset flag low while bus reset held");
	AST_HOST_SOFTWARE_SOURCE: assert property (@(posedge mclk)
		disable iff (rst) host_software_source_r |->
		$past(core_clk_on) && $past(host_software_source_en) && !core_boot_hold_r)
		else $error("host interrupt passed while gated");
endmodule
bind pcr_regs pcr_regs_asserts #(.HOLD_CYC(HOLD_CYC)) chk_u (
	.mclk(mclk), .rst(rst), .pci_clk(pci_clk), .pci_rst_n(pci_rst_n),
	.host_req(host_req), .core_req(core_req), .core_clk_on(core_clk_on),
	.host_software_source_en(host_software_source_en), .host_rdata_r(host_rdata_r),
	.host_rvalid_r(host_rvalid_r), .core_rdata_r(core_rdata_r),
	.core_rvalid_r(core_rvalid_r),
	.host_software_source_r(host_software_source_r),
	.core_boot_hold_r(core_boot_hold_r), .core_soft_hold_r(core_soft_hold_r),
	.page_r(page_r), .bus_irq_line_o_r(bus_irq_line_o_r),
	.bus_irq_line_oe_r(bus_irq_line_oe_r)
);

// [test/testbench.sv]
// Self-checking bench for the control register block.
`timescale 1ns/1ns
module testbench import pcr_pkg::*;;
	logic mclk = 1'b0;
	logic pci_clk = 1'b0;
	logic rst = 1'b1;
	logic pci_rst_n = 1'b0;
	logic boot_strap = 1'b0;
	logic map_strap = 1'b1;
	logic core_clk_on = 1'b1;
	logic host_software_source_en = 1'b1;
	logic pm_warm_req = 1'b0;
	pcr_core_req_t core_req = '0;
	pcr_host_req_t host_req;
	logic [31:0] host_rdata_r, core_rdata_r, d;
	logic host_rvalid_r, core_rvalid_r, host_software_source_r;
	logic core_boot_hold_r, core_soft_hold_r;
	logic bus_irq_line_o_r, bus_irq_line_oe_r;
	logic [9:0] page_r;
	int n_mismatch = 0;
	int checks_done = 0;
	// --------
	// Clocks, design and host
	// --------
	always #2 mclk = ~mclk;
	always #3 pci_clk = ~pci_clk;
	pcr_regs #(.HOLD_CYC(16)) dut_u (
		.mclk(mclk), .rst(rst), .pci_clk(pci_clk), .pci_rst_n(pci_rst_n),
		.boot_strap(boot_strap), .map_strap(map_strap), .host_req(host_req),
		.host_rdata_r(host_rdata_r), .host_rvalid_r(host_rvalid_r),
		.core_req(core_req), .core_rdata_r(core_rdata_r),
		.core_rvalid_r(core_rvalid_r), .core_clk_on(core_clk_on),
		.host_software_source_en(host_software_source_en), .pm_warm_req(pm_warm_req),
		.host_software_source_r(host_software_source_r),
		.core_boot_hold_r(core_boot_hold_r),
		.core_soft_hold_r(core_soft_hold_r), .page_r(page_r),
		.bus_irq_line_o_r(bus_irq_line_o_r),
		.bus_irq_line_oe_r(bus_irq_line_oe_r)
	);
	pcr_host_model host_u (
		.pci_clk(pci_clk), .host_req(host_req),
		.host_rdata_r(host_rdata_r), .host_rvalid_r(host_rvalid_r)
	);
	// --------
	// Access and check tasks
	// --------
	task test_done();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %0t: got %h want %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	// Waits for a level, or with stay set demands it for the whole window.
	task wsig(input int k, input logic v, input bit stay);
		logic s;
		bit ok;
		ok = stay;
		for (int i = 0; i < 40; i++) begin
			@(negedge mclk);
			s = k == 0 ? bus_irq_line_oe_r : k == 1 ? host_software_source_r :
				k == 2 ? core_boot_hold_r : core_soft_hold_r;
			if (stay && s !== v)
				ok = 1'b0;
			if (!stay && s === v) begin
				ok = 1'b1;
				break;
			end
		end
		checks_done++;
		if (!ok) begin
			$display("unexpected %0t: signal %0d not %b", $time, k, v);
			n_mismatch++;
			if (!stay)
				test_done();
		end
	endtask
	task crd(input logic [31:0] e);
		@(negedge mclk);
		core_req <= '{1'b1, 1'b0, 32'h0000_0000};
		@(negedge mclk);
		core_req <= '{1'b0, 1'b0, 32'hffff_ffff};
		chk(core_rvalid_r ? core_rdata_r : 32'hdead_beef, e);
	endtask
	task cwr(input logic [31:0] v);
		@(negedge mclk);
		core_req <= '{1'b1, 1'b1, v};
		@(negedge mclk);
		core_req <= '{1'b0, 1'b0, ~v};
	endtask
	task hrd(input logic [3:0] a, input logic [31:0] e);
		host_u.acc(1'b0, a, 4'hf, 32'h0000_0000, d);
		chk(d, e);
	endtask
	task hwr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] v);
		host_u.acc(1'b1, a, be, v, d);
	endtask
	task hirq(input logic on, input logic en, input logic e);
		core_clk_on <= on;
		host_software_source_en <= en;
		hwr(4'h4, 4'h1, 32'h0000_0002);
		wsig(1, e, !e);
	endtask
	// --------
	// Scenarios
	// --------
	task t_reset();
		crd(32'h0000_0003);
		crd(32'h0000_0000);
		hrd(4'h4, 32'h0000_0000);
		hrd(4'h8, 32'h0000_0400);
		hrd(4'hc, 32'h0000_0000);
	endtask
	task t_page();
		hwr(4'h8, 4'hf, 32'hffff_ffff);
		hrd(4'h8, 32'h0000_07ff);
		hwr(4'h8, 4'h1, 32'h0000_0000);
		hrd(4'h8, 32'h0000_0700);
		hwr(4'h4, 4'hf, 32'hffff_fff8);
		hrd(4'h4, 32'h0000_0000);
	endtask
	task t_soft();
		hwr(4'h4, 4'h1, 32'h0000_0000);
		wsig(3, 1'b0, 1'b1);
		hwr(4'h4, 4'h1, 32'h0000_0001);
		wsig(3, 1'b1, 1'b0);
		wsig(3, 1'b0, 1'b0);
		crd(32'h0000_0004);
		crd(32'h0000_0000);
		@(negedge mclk);
		pm_warm_req <= 1'b1;
		@(negedge mclk);
		pm_warm_req <= 1'b0;
		crd(32'h0000_0004);
	endtask
	task t_host_irq();
		hirq(1'b1, 1'b1, 1'b1);
		hirq(1'b1, 1'b0, 1'b0);
		hirq(1'b0, 1'b1, 1'b0);
		hrd(4'h4, 32'h0000_0000);
		@(negedge mclk);
		core_clk_on <= 1'b1;
	endtask
	task t_bus_irq();
		cwr(32'h0000_0008);
		wsig(0, 1'b1, 1'b0);
		hrd(4'h0, 32'h0000_0003);
		hwr(4'h0, 4'h1, 32'h0000_0004);
		wsig(0, 1'b0, 1'b0);
		hrd(4'h0, 32'h0000_0005);
		hwr(4'h0, 4'h1, 32'h0000_0000);
		wsig(0, 1'b1, 1'b0);
		hwr(4'h0, 4'h1, 32'h0000_0001);
		wsig(0, 1'b0, 1'b0);
		cwr(32'h0000_0008);
		wsig(0, 1'b0, 1'b1);
		cwr(32'h0000_0010);
		cwr(32'h0000_0008);
		wsig(0, 1'b1, 1'b0);
		cwr(32'h0000_0010);
		wsig(0, 1'b0, 1'b0);
		cwr(32'h0000_0018);
		wsig(0, 1'b1, 1'b0);
		cwr(32'h0000_0010);
		wsig(0, 1'b0, 1'b0);
	endtask
	task t_bus_rst();
		@(negedge mclk);
		pci_rst_n <= 1'b0;
		wsig(1, 1'b0, 1'b1);
		crd(32'h0000_0002);
		crd(32'h0000_0002);
		pci_rst_n <= 1'b1;
		repeat (10) @(negedge mclk);
		hrd(4'h8, 32'h0000_0400);
		hrd(4'h0, 32'h0000_0000);
	endtask
	task t_boot();
		@(negedge mclk);
		rst <= 1'b1;
		boot_strap <= 1'b1;
		repeat (8) @(negedge mclk);
		rst <= 1'b0;
		repeat (10) @(negedge mclk);
		wsig(2, 1'b1, 1'b1);
		hrd(4'h4, 32'h0000_0004);
		crd(32'h0000_0001);
		hwr(4'h4, 4'h1, 32'h0000_0002);
		wsig(2, 1'b0, 1'b0);
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		rst <= 1'b0;
		repeat (5) @(negedge mclk);
		pci_rst_n <= 1'b1;
		repeat (10) @(negedge mclk);
		t_reset();
		t_page();
		t_soft();
		t_host_irq();
		t_bus_irq();
		t_bus_rst();
		t_boot();
		test_done();
	end
endmodule
